//--- rtl/lpci_defs.svh
// lpci_defs.svh: pin command codes, bit positions and link clock phases
// assumes: included by bare name; sys clock is eight times the link clock
`ifndef LPCI_DEFS_SVH
`define LPCI_DEFS_SVH
// command codes as {cs_n, ras_n, cas_n, we_n}
`define LPCI_CMD_LMR      4'h0
`define LPCI_CMD_REF      4'h1
`define LPCI_CMD_PRE      4'h2
`define LPCI_CMD_ACT      4'h3
`define LPCI_CMD_WR       4'h4
`define LPCI_CMD_RD       4'h5
`define LPCI_CMD_DESEL    4'hF
`define LPCI_AP_BIT       10
// {ck_t, ck_c} levels
`define LPCI_CK_HI        2'h2
`define LPCI_CK_LO        2'h1
// link clock is high in phases 0..3 of eight
`define LPCI_CK_HALF      3'h4
`define LPCI_PH_READY     3'h2
`define LPCI_PH_PRE_FALL  3'h3
`define LPCI_PH_PRE_RISE  3'h7
`define LPCI_PH_PRE_LOMID 3'h5
`define LPCI_PH_PRE_HIMID 3'h1
`define LPCI_PH_RESET     3'h7
`define LPCI_RD_TIMEOUT   5'h1F
`endif

//--- rtl/lpci_pkg.sv
// lpci_pkg: shared types of the lpddr pin command interface
// assumes: used by scope, never imported
package lpci_pkg;
    typedef enum logic [3:0] {
        OP_ACT = 4'h0, OP_RD = 4'h1, OP_WR = 4'h2, OP_PRE = 4'h3, OP_LMR = 4'h4,
        OP_REF = 4'h5, OP_SREF = 4'h6, OP_PDN = 4'h7, OP_PUP = 4'h8
    } lpci_op_type;
    typedef enum logic [3:0] {
        PWR_RUN = 4'h1, PWR_PPD = 4'h2, PWR_APD = 4'h4, PWR_SREF = 4'h8
    } lpci_pwr_type;
    typedef enum logic [3:0] {
        CS_IDLE = 4'h1, CS_CMD = 4'h2, CS_WDAT = 4'h4, CS_RDAT = 4'h8
    } lpci_cst_type;
    typedef enum logic [3:0] {
        RS_IDLE = 4'h1, RS_ARM = 4'h2, RS_B0 = 4'h4, RS_B1 = 4'h8
    } lpci_rst_type;
endpackage : lpci_pkg

//--- rtl/lpci_if.sv
// lpci_if: the pins between memory controller and memory device
// assumes: two-way pins resolve here; an undriven bus reads as zero
`timescale 1ns/1ns
interface lpci_if #(parameter int DW = 16, parameter int AW = 13);
    localparam int NB = DW / 8;
    logic          ck_t;
    logic          ck_c;
    logic          cke;
    logic          cs_n;
    logic          ras_n;
    logic          cas_n;
    logic          we_n;
    logic          bank_select_lo;
    logic          bank_select_hi;
    logic [AW-1:0] addr;
    logic          extra_row_bit;
    logic [NB-1:0] byte_mask_lanes;
    logic [DW-1:0] dq_ctl_o;
    logic          dq_ctl_oe_n;
    logic [DW-1:0] dq_dev_o;
    logic          dq_dev_oe_n;
    logic [NB-1:0] dqs_ctl_o;
    logic [NB-1:0] dqs_dev_o;
    logic [DW-1:0] dq;
    logic [NB-1:0] dqs;
    assign dq  = !dq_ctl_oe_n ? dq_ctl_o : (!dq_dev_oe_n ? dq_dev_o : '0);
    assign dqs = !dq_ctl_oe_n ? dqs_ctl_o : (!dq_dev_oe_n ? dqs_dev_o : '0);
    modport ctl (output ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi,
                 addr, extra_row_bit, byte_mask_lanes, dq_ctl_o, dq_ctl_oe_n, dqs_ctl_o,
                 input dq, dqs);
    modport dev (input ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi,
                 addr, extra_row_bit, byte_mask_lanes, dq, dqs,
                 output dq_dev_o, dq_dev_oe_n, dqs_dev_o);
endinterface : lpci_if

//--- rtl/lpci_fifo.sv
// lpci_fifo: write data buffer, valid and ready on both sides
// assumes: DEPTH is two to the power PW
`timescale 1ns/1ns
module lpci_fifo #(parameter int W = 18, parameter int DEPTH = 16, parameter int PW = 4) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         sys_rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0]  mem_q [0:DEPTH-1];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0]   cnt_q;
    logic [PW:0]   cnt_d;
    logic          rdy_q;
    logic          vld_q;
    wire           push = in_valid && rdy_q;
    wire           pop  = out_ready && vld_q;
    // flags are registered from the next count so both sides see flops
    assign cnt_d     = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    assign in_ready  = rdy_q;
    assign out_valid = vld_q;
    assign out_data  = mem_q[rp_q];
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end else begin
            wp_q  <= wp_q + PW'(push);
            rp_q  <= rp_q + PW'(pop);
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != (PW+1)'(DEPTH);
            vld_q <= cnt_d != '0;
        end
    end
endmodule : lpci_fifo

//--- rtl/lpci_ctl.sv
// lpci_ctl: memory controller end; makes the link clock, drives commands, moves data
// assumes: device end on the far side of lpci_if; user holds cmd fields while cmd_valid
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "lpci_defs.svh"
module lpci_ctl #(parameter int DW = 16, parameter int AW = 13, parameter bit REDUCED_PAGE = 1'b0,
                  parameter int FIFO_DEPTH = 16, parameter int FIFO_PW = 4) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // pins
    lpci_if.ctl                        pins,
    // command port
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire lpci_pkg::lpci_op_type cmd_op,
    input  wire logic [1:0]            cmd_bank,
    input  wire logic [AW:0]           cmd_addr,
    // write data, one beat per word
    input  wire logic                  wr_valid,
    output logic                       wr_ready,
    input  wire logic [DW-1:0]         wr_data,
    input  wire logic [DW/8-1:0]       wr_mask,
    // read data, one beat per pulse
    output logic                       rd_valid,
    output logic [DW-1:0]              rd_data
);
    localparam int NB = DW / 8;
    localparam int SW = 1 + DW;
    lpci_pkg::lpci_cst_type st_q, st_d;
    lpci_pkg::lpci_op_type  op_q;
    logic [2:0]    ph_q;
    logic          ck_q, ckc_q, cke_q, rdy_q, oe_n_q, xrb_q, rv_q, rb_q;
    logic [3:0]    code_q, op_code;
    logic          op_cke;
    logic [1:0]    bank_q;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] dq_q, rd_q;
    logic [NB-1:0] mask_q, dqs_q;
    logic [4:0]    tmo_q;
    logic [SW-1:0] s1_q, s2_q, s3_q, sy_q;
    logic          pv_dqs_q;
    logic          f_valid, f_pop;
    logic [NB+DW-1:0] f_data;
    wire at_fall  = ph_q == `LPCI_PH_PRE_FALL;
    wire at_rise  = ph_q == `LPCI_PH_PRE_RISE;
    wire at_lomid = ph_q == `LPCI_PH_PRE_LOMID;
    wire at_himid = ph_q == `LPCI_PH_PRE_HIMID;
    wire take     = rdy_q && cmd_valid;
    wire [SW-1:0] agree = ~(s2_q ^ s3_q);
    wire [SW-1:0] sy_d  = (agree & s3_q) | (~agree & sy_q);
    wire          p_dqs = sy_q[DW];
    wire          dqs_edge = (p_dqs != pv_dqs_q) && (st_q == lpci_pkg::CS_RDAT);
    // a missing beat goes out fully masked, so the device drops it
    wire [NB-1:0] beat_mask = f_valid ? f_data[NB+DW-1:DW] : {NB{1'b1}};
    assign f_pop = f_valid && ((st_q == lpci_pkg::CS_CMD && at_fall && op_q == lpci_pkg::OP_WR)
                               || (st_q == lpci_pkg::CS_WDAT && at_rise));
    lpci_fifo #(.W(NB + DW), .DEPTH(FIFO_DEPTH), .PW(FIFO_PW)) u_wfifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_mask, wr_data}),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );
    always_comb begin
        op_code = `LPCI_CMD_DESEL;
        op_cke  = cke_q;
        case (cmd_op)
            lpci_pkg::OP_ACT: op_code = `LPCI_CMD_ACT;
            lpci_pkg::OP_RD:  op_code = `LPCI_CMD_RD;
            lpci_pkg::OP_WR:  op_code = `LPCI_CMD_WR;
            lpci_pkg::OP_PRE: op_code = `LPCI_CMD_PRE;
            lpci_pkg::OP_LMR: op_code = `LPCI_CMD_LMR;
            lpci_pkg::OP_REF: op_code = `LPCI_CMD_REF;
            lpci_pkg::OP_SREF: begin
                op_code = `LPCI_CMD_REF;
                op_cke  = 1'b0;
            end
            lpci_pkg::OP_PDN: op_cke = 1'b0;
            lpci_pkg::OP_PUP: op_cke = 1'b1;
            default: op_code = `LPCI_CMD_DESEL;
        endcase
    end
    always_comb begin
        st_d = st_q;
        case (st_q)
            lpci_pkg::CS_IDLE: if (take) st_d = lpci_pkg::CS_CMD;
            lpci_pkg::CS_CMD: begin
                if (at_fall) begin
                    if (op_q == lpci_pkg::OP_WR) st_d = lpci_pkg::CS_WDAT;
                    else if (op_q == lpci_pkg::OP_RD) st_d = lpci_pkg::CS_RDAT;
                    else st_d = lpci_pkg::CS_IDLE;
                end
            end
            lpci_pkg::CS_WDAT: if (at_fall) st_d = lpci_pkg::CS_IDLE;
            lpci_pkg::CS_RDAT: begin
                if ((dqs_edge && rb_q) || tmo_q == `LPCI_RD_TIMEOUT) st_d = lpci_pkg::CS_IDLE;
            end
            default: st_d = lpci_pkg::CS_IDLE;
        endcase
    end
    // commands change on the link clock fall and are held through the rise
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_q <= lpci_pkg::CS_IDLE;
            op_q <= lpci_pkg::OP_PUP;
            ph_q <= `LPCI_PH_RESET;
            ck_q <= 1'b0;
            ckc_q <= 1'b1;
            cke_q <= 1'b1;
            rdy_q <= 1'b0;
            code_q <= `LPCI_CMD_DESEL;
            bank_q <= 2'h0;
            addr_q <= '0;
            xrb_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            ph_q  <= ph_q + 3'h1;
            ck_q  <= (ph_q + 3'h1) < `LPCI_CK_HALF;
            ckc_q <= !((ph_q + 3'h1) < `LPCI_CK_HALF);
            rdy_q <= (st_d == lpci_pkg::CS_IDLE) && ph_q == `LPCI_PH_READY;
            if (take) begin
                op_q   <= cmd_op;
                code_q <= op_code;
                cke_q  <= op_cke;
                bank_q <= cmd_bank;
                addr_q <= cmd_addr[AW-1:0];
                xrb_q  <= REDUCED_PAGE ? cmd_addr[AW] : 1'b0;
            end else if (st_q == lpci_pkg::CS_CMD && at_fall) begin
                code_q <= `LPCI_CMD_DESEL;
            end
        end
    end
    // write beats: strobe rises and falls mid-beat
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oe_n_q <= 1'b1;
            dq_q   <= '0;
            mask_q <= '0;
            dqs_q  <= '0;
        end else if (st_q == lpci_pkg::CS_CMD && at_fall && op_q == lpci_pkg::OP_WR) begin
            oe_n_q <= 1'b0;
            dq_q   <= f_data[DW-1:0];
            mask_q <= beat_mask;
            dqs_q  <= '0;
        end else if (st_q == lpci_pkg::CS_WDAT) begin
            if (at_lomid || at_himid) dqs_q <= {NB{at_lomid}};
            if (at_rise) dq_q <= f_data[DW-1:0];
            if (at_rise) mask_q <= beat_mask;
            if (at_fall) oe_n_q <= 1'b1;
        end
    end
    // read capture on the device strobe, both edges
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sy_q <= '0;
            pv_dqs_q <= 1'b0;
            rv_q <= 1'b0;
            rd_q <= '0;
            rb_q <= 1'b0;
            tmo_q <= 5'h00;
        end else begin
            s1_q <= {pins.dqs[0], pins.dq};
            s2_q <= s1_q;
            s3_q <= s2_q;
            sy_q <= sy_d;
            pv_dqs_q <= p_dqs;
            rv_q <= dqs_edge;
            if (dqs_edge) rd_q <= sy_q[DW-1:0];
            rb_q <= (st_q == lpci_pkg::CS_RDAT) ? (rb_q ^ dqs_edge) : 1'b0;
            tmo_q <= (st_q == lpci_pkg::CS_RDAT) ? tmo_q + 5'h01 : 5'h00;
        end
    end
    assign cmd_ready = rdy_q;
    assign rd_valid = rv_q;
    assign rd_data = rd_q;
    assign pins.ck_t = ck_q;
    assign pins.ck_c = ckc_q;
    assign pins.cke = cke_q;
    assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = code_q;
    assign {pins.bank_select_hi, pins.bank_select_lo} = bank_q;
    assign pins.addr = addr_q;
    assign pins.extra_row_bit = xrb_q;
    assign pins.byte_mask_lanes = mask_q;
    assign pins.dq_ctl_o = dq_q;
    assign pins.dq_ctl_oe_n = oe_n_q;
    assign pins.dqs_ctl_o = dqs_q;
endmodule : lpci_ctl

//--- rtl/lpci_dev.sv
// lpci_dev: memory device end; samples pins, decodes commands, tracks banks and power
// assumes: controller on lpci_if makes the link clock; every pin but the upper strobe bit enters through four flops
`timescale 1ns/1ns
`include "lpci_defs.svh"
// Functional notes
// - sample commands on rising clock crossing
// - data moves on both clock crossings
// - clock-gate high enables inputs and drivers
// - clock-gate low picks power-down kind by banks
// - self refresh exit ignores clock edges
// - power-down ignores all inputs but clock-gate; here power-down exit also waits for a clock rise
// - chip select high masks every command
// - command from select and three strobes
// - masked write bytes are discarded
// - byte mask sampled on both strobe edges
// - bank select picks the addressed bank
// - bank select picks the mode register
// - row on activate, column and auto precharge
// - precharge one bank or all by bit ten
// - mode op-code taken from address lines
// - strobe edge-aligned reads, centered writes
// - data bus sixteen or thirty-two bits
// - extra row bit only in reduced page
module lpci_dev #(parameter int DW = 16, parameter int AW = 13, parameter bit REDUCED_PAGE = 1'b0,
                  parameter int MEM_AW = 6) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // pins
    lpci_if.dev                         pins,
    // status
    output lpci_pkg::lpci_pwr_type      dev_pwr_state,
    output logic [3:0]                  dev_bank_open,
    output logic [4*(AW+1)-1:0]         dev_mode_regs
);
    localparam int NB    = DW / 8;
    localparam int RW    = AW + 1;
    localparam int SW    = 11 + AW + NB + DW;
    localparam int DEPTH = 1 << MEM_AW;
    localparam int CW    = MEM_AW - 2;

    // pin synchroniser, a bit moves once stages two and three agree
    logic [SW-1:0] s1_q, s2_q, s3_q, st_q;
    logic [1:0]    pv_ck_q;
    logic          pv_dqs_q;
    wire  [SW-1:0] agree = ~(s2_q ^ s3_q);
    wire  [SW-1:0] st_d  = (agree & s3_q) | (~agree & st_q);
    logic          p_ckt, p_ckc, p_cke, p_csn, p_rasn, p_casn, p_wen, p_bhi, p_blo, p_xrb, p_dqs;
    logic [AW-1:0] p_addr;
    logic [NB-1:0] p_mask;
    logic [DW-1:0] p_dq;
    assign {p_ckt, p_ckc, p_cke, p_csn, p_rasn, p_casn, p_wen, p_bhi, p_blo, p_xrb,
            p_addr, p_mask, p_dqs, p_dq} = st_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            st_q     <= '0;
            pv_ck_q  <= 2'h0;
            pv_dqs_q <= 1'b0;
        end else begin
            s1_q <= {pins.ck_t, pins.ck_c, pins.cke, pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n,
                     pins.bank_select_hi, pins.bank_select_lo, pins.extra_row_bit, pins.addr,
                     pins.byte_mask_lanes, pins.dqs[0], pins.dq};
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            st_q     <= st_d;
            pv_ck_q  <= {p_ckt, p_ckc};
            pv_dqs_q <= p_dqs;
        end
    end

    // crossings and command decode
    lpci_pkg::lpci_pwr_type pwr_q, pwr_d;
    wire       ck_rise  = ({p_ckt, p_ckc} == `LPCI_CK_HI) && (pv_ck_q == `LPCI_CK_LO);
    wire       ck_fall  = ({p_ckt, p_ckc} == `LPCI_CK_LO) && (pv_ck_q == `LPCI_CK_HI);
    wire       dqs_edge = p_dqs != pv_dqs_q;
    wire       awake    = pwr_q == lpci_pkg::PWR_RUN;
    wire [3:0] code     = {p_csn, p_rasn, p_casn, p_wen};
    // inputs count only when running, gated on and selected
    wire       take     = ck_rise && awake && p_cke && !p_csn;
    wire       do_act   = take && code == `LPCI_CMD_ACT;
    wire       do_rd    = take && code == `LPCI_CMD_RD;
    wire       do_wr    = take && code == `LPCI_CMD_WR;
    wire       do_pre   = take && code == `LPCI_CMD_PRE;
    wire       do_lmr   = take && code == `LPCI_CMD_LMR;
    wire [1:0] bank     = {p_bhi, p_blo};
    wire       ap       = p_addr[`LPCI_AP_BIT];
    // the extra row bit is ignored unless the reduced page option is built
    wire [RW-1:0]     row     = REDUCED_PAGE ? {p_xrb, p_addr} : {1'b0, p_addr};
    wire [MEM_AW-1:0] col_idx = {bank, p_addr[CW-1:1], 1'b0};

    // per-bank row state and mode registers
    logic [3:0] open_w;
    logic       xfer_done;
    wire        all_idle = open_w == 4'h0;
    for (genvar b = 0; b < 4; b++) begin : g_bank
        logic          open_q, apend_q;
        logic [RW-1:0] row_q, mode_q;
        wire hit   = bank == 2'(b);
        wire close = (do_pre && (hit || ap)) || (xfer_done && apend_q);
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                open_q  <= 1'b0;
                apend_q <= 1'b0;
                row_q   <= '0;
                mode_q  <= '0;
            end else begin
                if (do_act && hit) open_q <= 1'b1;
                else if (close) open_q <= 1'b0;
                if (do_act && hit) row_q <= row;
                if ((do_rd || do_wr) && hit) apend_q <= ap;
                else if (xfer_done) apend_q <= 1'b0;
                if (do_lmr && hit) mode_q <= row;
            end
        end
        assign open_w[b] = open_q;
        assign dev_mode_regs[b*RW +: RW] = mode_q;
    end

    // power state; only self refresh exit is taken without a clock crossing
    wire sref_go = ck_rise && !p_csn && code == `LPCI_CMD_REF && all_idle;
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            lpci_pkg::PWR_RUN: begin
                if (ck_rise && !p_cke) begin
                    if (sref_go) pwr_d = lpci_pkg::PWR_SREF;
                    else if (all_idle) pwr_d = lpci_pkg::PWR_PPD;
                    else pwr_d = lpci_pkg::PWR_APD;
                end
            end
            lpci_pkg::PWR_PPD: if (ck_rise && p_cke) pwr_d = lpci_pkg::PWR_RUN;
            lpci_pkg::PWR_APD: if (ck_rise && p_cke) pwr_d = lpci_pkg::PWR_RUN;
            lpci_pkg::PWR_SREF: if (p_cke) pwr_d = lpci_pkg::PWR_RUN;
            default: pwr_d = lpci_pkg::PWR_RUN;
        endcase
    end

    // write capture on controller strobe edges
    logic              wr_on_q, wbeat_q;
    logic [MEM_AW-1:0] widx_q;
    wire               wr_stb = wr_on_q && dqs_edge && awake;
    wire [MEM_AW-1:0]  widx   = {widx_q[MEM_AW-1:1], wbeat_q};

    // read launch, strobe high with beat zero and low with beat one
    lpci_pkg::lpci_rst_type rs_q, rs_d;
    logic [MEM_AW-1:0] ridx_q;
    logic [DW-1:0]     rd_word, dq_q;
    logic [NB-1:0]     dqs_q;
    logic              oe_n_q;
    wire [MEM_AW-1:0]  ridx   = {ridx_q[MEM_AW-1:1], rs_q == lpci_pkg::RS_B0};
    wire               rd_end = rs_q == lpci_pkg::RS_B1 && ck_rise;
    wire               drive  = rs_d == lpci_pkg::RS_B0 || rs_d == lpci_pkg::RS_B1;
    wire               load   = (rs_q == lpci_pkg::RS_ARM && ck_rise) || (rs_q == lpci_pkg::RS_B0 && ck_fall);
    assign xfer_done = (wr_stb && wbeat_q) || rd_end;

    for (genvar l = 0; l < NB; l++) begin : g_lane
        logic [7:0] mem_q [0:DEPTH-1];
        always_ff @(posedge clock) begin
            if (wr_stb && !p_mask[l]) mem_q[widx] <= p_dq[8*l +: 8];
        end
        assign rd_word[8*l +: 8] = mem_q[ridx];
    end

    always_comb begin
        rs_d = rs_q;
        case (rs_q)
            lpci_pkg::RS_IDLE: if (do_rd) rs_d = lpci_pkg::RS_ARM;
            lpci_pkg::RS_ARM:  if (ck_rise) rs_d = lpci_pkg::RS_B0;
            lpci_pkg::RS_B0:   if (ck_fall) rs_d = lpci_pkg::RS_B1;
            lpci_pkg::RS_B1:   if (ck_rise) rs_d = do_rd ? lpci_pkg::RS_ARM : lpci_pkg::RS_IDLE;
            default: rs_d = lpci_pkg::RS_IDLE;
        endcase
        // drivers go quiet at the first clock rise that sees the clock gate low, or when not running
        if (!awake || (ck_rise && !p_cke)) rs_d = lpci_pkg::RS_IDLE;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pwr_q   <= lpci_pkg::PWR_RUN;
            wr_on_q <= 1'b0;
            wbeat_q <= 1'b0;
            widx_q  <= '0;
            rs_q    <= lpci_pkg::RS_IDLE;
            ridx_q  <= '0;
        end else begin
            pwr_q <= pwr_d;
            rs_q  <= rs_d;
            if (do_rd) ridx_q <= col_idx;
            if (do_wr) begin
                wr_on_q <= 1'b1;
                wbeat_q <= 1'b0;
                widx_q  <= col_idx;
            end else if (!awake || (wr_stb && wbeat_q)) begin
                wr_on_q <= 1'b0;
            end else if (wr_stb) begin
                wbeat_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dq_q   <= '0;
            dqs_q  <= '0;
            oe_n_q <= 1'b1;
        end else begin
            if (load) dq_q <= rd_word;
            dqs_q  <= {NB{rs_d == lpci_pkg::RS_B0}};
            oe_n_q <= !drive;
        end
    end

    assign pins.dq_dev_o    = dq_q;
    assign pins.dqs_dev_o   = dqs_q;
    assign pins.dq_dev_oe_n = oe_n_q;
    assign dev_pwr_state    = pwr_q;
    assign dev_bank_open    = open_w;
endmodule : lpci_dev

//--- verification/lpci_props.sv
// lpci_props: checks on the link pins
// assumes: sits beside lpci_if; one clock domain
`timescale 1ns/1ns
module lpci_props #(parameter bit REDUCED_PAGE = 1'b0) (
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // link pins
    input wire logic       ck_t,
    input wire logic       ck_c,
    input wire logic       cs_n,
    input wire logic       extra_row_bit,
    input wire logic       dq_ctl_oe_n,
    input wire logic [1:0] dqs_ctl_o,
    input wire logic       dq_dev_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // strobe edges fall mid-beat, so the device never catches data in transition
    sequence wr_dqs_s;
        (dqs_ctl_o == 2'h0)[*2] ##1 (dqs_ctl_o == 2'h3)[*4] ##1 dqs_ctl_o == 2'h0;
    endsequence
    ck_pair_a: assert property (ck_t != ck_c) else $error("ck pair");
    ck_period_a: assert property ($rose(ck_t) |-> ck_t[*4] ##1 !ck_t[*4] ##1 ck_t) else $error("ck period");
    cmd_stable_a: assert property ($rose(ck_t) |-> $stable(cs_n)) else $error("cs moved");
    cmd_hold_a: assert property ($fell(cs_n) |-> !cs_n[*8]) else $error("cs short");
    row_bit_a: assert property (!REDUCED_PAGE |-> !extra_row_bit) else $error("row bit");
    bus_fight_a: assert property (dq_ctl_oe_n || dq_dev_oe_n) else $error("both drive");
    wr_len_a: assert property ($fell(dq_ctl_oe_n) |-> !dq_ctl_oe_n[*8] ##1 dq_ctl_oe_n) else $error("wr len");
    wr_dqs_a: assert property ($fell(dq_ctl_oe_n) |-> wr_dqs_s) else $error("wr strobe");
endmodule : lpci_props

//--- verification/lpddr_pin_command_interface_bench.sv
// lpddr_pin_command_interface_bench: both ends joined, checked against a model
// assumes: rtl files and lpci_props compiled first
`timescale 1ns/1ns
module lpddr_pin_command_interface_bench;
    logic                   clock, sys_rst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid;
    logic [1:0]             cmd_bank, wr_mask, m, mq[$];
    logic [3:0]             bank_open;
    // an activate while in power-down must be ignored; a refresh with the gate high stays running
    logic [7:0]             pt[9] = '{8'h72, 8'h02, 8'h81, 8'h68, 8'h81, 8'h01, 8'h74, 8'h81, 8'h51};
    logic [13:0]            cmd_addr, op;
    logic [15:0]            wr_data, rd_data, d, mem[int], fq[$], eq[$], rq[$];
    logic [55:0]            mode_regs;
    int                     n_errors, n_checks, j;
    lpci_pkg::lpci_op_type  cmd_op;
    lpci_pkg::lpci_pwr_type pwr;
    lpci_if lnk ();
    lpci_ctl lpci_ctl_inst (.clock, .sys_rst, .pins(lnk), .cmd_valid, .cmd_ready, .cmd_op, .cmd_bank, .cmd_addr,
        .wr_valid, .wr_ready, .wr_data, .wr_mask, .rd_valid, .rd_data);
    lpci_dev lpci_dev_inst (.clock, .sys_rst, .pins(lnk), .dev_pwr_state(pwr), .dev_bank_open(bank_open),
        .dev_mode_regs(mode_regs));
    lpci_props lpci_props_inst (.clock, .sys_rst, .ck_t(lnk.ck_t), .ck_c(lnk.ck_c), .cs_n(lnk.cs_n),
        .extra_row_bit(lnk.extra_row_bit), .dq_ctl_oe_n(lnk.dq_ctl_oe_n), .dqs_ctl_o(lnk.dqs_ctl_o),
        .dq_dev_oe_n(lnk.dq_dev_oe_n));
    always @(negedge clock) if (rd_valid === 1'b1) rq.push_back(rd_data);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // the wait covers a read's two beats, so the model never races the device
    task automatic cmd(input logic [3:0] o, input logic [1:0] b, input logic [13:0] a);
        cmd_op <= lpci_pkg::lpci_op_type'(o);
        cmd_bank <= b;
        cmd_addr <= a;
        cmd_valid <= 1'b1;
        do @(negedge clock); while (cmd_ready !== 1'b1);
        @(posedge clock);
        cmd_valid <= 1'b0;
        repeat (48) @(posedge clock);
    endtask : cmd
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6000) @(posedge clock);
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(85));
        {sys_rst, cmd_valid, wr_valid} = 3'h4;
        {cmd_bank, wr_mask, cmd_addr, wr_data} = '0;
        cmd_op = lpci_pkg::OP_ACT;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        for (int b = 0; b < 4; b++) begin
            op = 14'($urandom) & 14'h1FFF;
            cmd(4'h4, b[1:0], op);
            chk(mode_regs[b*14+:14], op);
        end
        for (int b = 0; b < 4; b++) cmd(4'h0, b[1:0], 14'($urandom));
        chk(bank_open, 4'hF);
        cmd(4'h3, 2'h2, 14'h0);
        chk(bank_open, 4'hB);
        cmd(4'h3, 2'h0, 14'h400);
        chk(bank_open, 4'h0);
        for (int i = 0; i < 9; i++) begin
            cmd(pt[i][7:4], 2'h1, 14'h0);
            chk(pwr, pt[i][3:0]);
        end
        // first round unmasked so every word the reads touch is known
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 16; k++) begin
                d = 16'($urandom);
                m = r ? 2'($urandom) : 2'h0;
                wr_data <= d;
                wr_mask <= m;
                wr_valid <= 1'b1;
                fq.push_back(d);
                mq.push_back(m);
                @(posedge clock);
            end
            wr_valid <= 1'b0;
            repeat (2) @(negedge clock);
            chk(wr_ready, 1'b0);
            for (int i = 0; i < 8; i++) begin
                cmd(4'h2, i[1:0], 14'(i * 2));
                for (int k = 0; k < 2; k++) begin
                    d = fq.pop_front();
                    m = mq.pop_front();
                    j = i % 4 * 16 + i * 2 + k;
                    for (int y = 0; y < 2; y++) if (!m[y]) mem[j][y*8+:8] = d[y*8+:8];
                end
            end
        end
        for (int i = 0; i < 8; i++) begin
            // the second read to bank one asks for auto precharge, closing the only open row
            cmd(4'h1, i[1:0], 14'(i * 2) | (i == 5 ? 14'h400 : 14'h0));
            eq.push_back(mem[i % 4 * 16 + i * 2]);
            eq.push_back(mem[i % 4 * 16 + i * 2 + 1]);
        end
        chk(rq.size(), 32'h10);
        foreach (eq[k]) chk(rq[k], eq[k]);
        chk(bank_open, 4'h0);
        wrap_up();
    end
endmodule : lpddr_pin_command_interface_bench
